// ===== rtl/sla_annunciator.sv
// status lamp annunciator top: heartbeat, fault flash, source, timer and exerciser lamps
`timescale 1ns/10ps
`default_nettype none
module sla_annunciator
  import sla_pkg::*;
#(
  parameter int unsigned BLINK_HALF = SLA_BLINK_HALF_CYC,
  parameter int unsigned FLASH_ON = SLA_FLASH_ON_CYC,
  parameter int unsigned DIGIT_GAP = SLA_DIGIT_GAP_CYC,
  parameter int unsigned REPEAT_GAP = SLA_REPEAT_GAP_CYC
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire sla_ctrl_t ctrl_in,
  input wire sla_stat_t stat_in,
  input wire logic event_raise_in,
  input wire logic [4*SLA_DIGITS-1:0] event_code_in,
  input wire logic panel_reset_in,
  input wire logic exer_button_in,
  input wire logic exer_display_toggle_in,
  input wire logic power_lost_in,
  input wire logic shutdown_done_in,
  output logic status_led_out,
  output logic src1_led_out,
  output logic src2_led_out,
  output logic gen_a_led_out,
  output logic gen_b_led_out,
  output logic retransfer_led_out,
  output logic transfer_led_out,
  output logic neutral_pos_led_out,
  output logic exerciser_led_out,
  output logic exercise_enabled_out,
  output logic event_active_out,
  output logic neutral_warn_out,
  output logic preferred_event_out,
  output logic net_shutdown_out,
  output logic shutdown_start_out,
  output logic power_off_out
);
  // ==========================================================
  // reset release
  logic rst_s1, rst_n;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // ==========================================================
  // shared blink square wave
  logic blink_tick, blink;
  sla_tick #(.PERIOD(BLINK_HALF)) u_blink (
    .clock_in(clock_in),
    .rst_n(rst_n),
    .clear_in(1'b0),
    .tick_out(blink_tick)
  );
  // one second on, one second off, shared by every blinking lamp
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      blink <= 1'b0;
    end else if (blink_tick) begin
      blink <= !blink;
    end
  end

  // ==========================================================
  // event latch and fault flash
  logic event_active;
  logic [4*SLA_DIGITS-1:0] code_held;
  logic flash_lamp;
  // a new event beats an acknowledge in the same cycle
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      event_active <= 1'b0;
      code_held <= '0;
    end else if (event_raise_in) begin
      event_active <= 1'b1;
      code_held <= event_code_in;
    end else if (panel_reset_in) begin
      event_active <= 1'b0; // acknowledge ends the flash-out
    end
  end
  sla_flash #(
    .FLASH_ON(FLASH_ON),
    .DIGIT_GAP(DIGIT_GAP),
    .REPEAT_GAP(REPEAT_GAP)
  ) u_flash (
    .clock_in(clock_in),
    .rst_n(rst_n),
    .run_in(event_active),
    .code_in(code_held),
    .lamp_out(flash_lamp)
  );

  // ==========================================================
  // exerciser enable
  logic button_d, exercise_enabled;
  wire logic button_press = exer_button_in && !button_d;
  wire logic exer_toggle = button_press ^ exer_display_toggle_in;
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      button_d <= 1'b0;
      exercise_enabled <= 1'b0;
    end else begin
      button_d <= exer_button_in;
      exercise_enabled <= exercise_enabled ^ exer_toggle; // press or display toggles
    end
  end

  // ==========================================================
  // preferred source change event
  logic pref_d;
  logic preferred_event;
  wire logic pref_changed = stat_in.preferred_is_src2 != pref_d;
  // clear while preferred is source one wins: the event only ever stands for source two
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      pref_d <= 1'b0;
      preferred_event <= 1'b0;
    end else begin
      pref_d <= stat_in.preferred_is_src2;
      if (!stat_in.util_to_util_mode || !stat_in.preferred_is_src2) begin
        preferred_event <= 1'b0;
      end else if (pref_changed) begin
        preferred_event <= 1'b1;
      end
    end
  end

  // ==========================================================
  // loss of power sequence
  typedef enum logic [1:0] {SLA_PWR_RUN, SLA_PWR_SHUT, SLA_PWR_OFF} sla_pstate_t;
  sla_pstate_t pstate;
  // power off is final until reset: batteries are being saved
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      pstate <= SLA_PWR_RUN;
    end else begin
      unique case (pstate)
        SLA_PWR_RUN: if (power_lost_in) pstate <= SLA_PWR_SHUT;
        SLA_PWR_SHUT: if (shutdown_done_in) pstate <= SLA_PWR_OFF;
        SLA_PWR_OFF: pstate <= SLA_PWR_OFF;
        default: pstate <= SLA_PWR_RUN;
      endcase
    end
  end

  // ==========================================================
  // lamp selection
  wire logic next_status = event_active ? flash_lamp : blink;
  wire logic next_gen_a = ctrl_in.gen_a_start_cmd || (ctrl_in.gen_a_start_delay && blink);
  wire logic gen_b_cmd = stat_in.gen_to_gen_mode && ctrl_in.gen_b_start_cmd;
  wire logic next_gen_b = gen_b_cmd || (ctrl_in.gen_b_start_delay && blink);
  wire logic next_retx = ctrl_in.retransfer_relay || (ctrl_in.retransfer_delay && blink);
  wire logic next_xfer = ctrl_in.transfer_relay || (ctrl_in.transfer_delay && blink);
  wire logic next_neutral = ctrl_in.neutral_position_delay && blink;
  // exercise period blinks, else steady while enabled; disabled is dark
  wire logic next_exer = exercise_enabled && (ctrl_in.exercise_active ? blink : 1'b1);
  wire logic next_nwarn = stat_in.load_monitor_fitted && stat_in.neutral_over;

  // ==========================================================
  // output registers
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      status_led_out <= 1'b0;
      src1_led_out <= 1'b0;
      src2_led_out <= 1'b0;
      gen_a_led_out <= 1'b0;
      gen_b_led_out <= 1'b0;
      retransfer_led_out <= 1'b0;
      transfer_led_out <= 1'b0;
      neutral_pos_led_out <= 1'b0;
      exerciser_led_out <= 1'b0;
      exercise_enabled_out <= 1'b0;
      event_active_out <= 1'b0;
      neutral_warn_out <= 1'b0;
      preferred_event_out <= 1'b0;
      net_shutdown_out <= 1'b0;
      shutdown_start_out <= 1'b0;
      power_off_out <= 1'b0;
    end else begin
      status_led_out <= next_status;
      src1_led_out <= stat_in.src1_ok;
      src2_led_out <= stat_in.src2_ok;
      gen_a_led_out <= next_gen_a;
      gen_b_led_out <= next_gen_b;
      retransfer_led_out <= next_retx;
      transfer_led_out <= next_xfer;
      neutral_pos_led_out <= next_neutral;
      exerciser_led_out <= next_exer;
      exercise_enabled_out <= exercise_enabled;
      event_active_out <= event_active;
      neutral_warn_out <= next_nwarn;
      preferred_event_out <= preferred_event;
      net_shutdown_out <= (pstate != SLA_PWR_RUN);
      shutdown_start_out <= (pstate == SLA_PWR_SHUT);
      power_off_out <= (pstate == SLA_PWR_OFF);
    end
  end

  // ==========================================================
  // checks
  logic blink_q;
  always_ff @(posedge clock_in) blink_q <= blink;

  heartbeat_idle_a: assert property (@(posedge clock_in) disable iff (!rst_n)
    !event_active ##1 !event_active |-> status_led_out == $past(blink))
    else $error("heartbeat not shown while idle");
  flash_ack_a: assert property (@(posedge clock_in) disable iff (!rst_n)
    panel_reset_in && !event_raise_in |=> !event_active)
    else $error("acknowledge did not end flash");
  src1_lamp_a: assert property (@(posedge clock_in) disable iff (!rst_n)
    1'b1 |=> src1_led_out == $past(stat_in.src1_ok))
    else $error("source one lamp mismatch");
  gen_a_steady_a: assert property (@(posedge clock_in) disable iff (!rst_n)
    ctrl_in.gen_a_start_cmd |=> gen_a_led_out)
    else $error("gen a lamp not steady");
  gen_b_mode_a: assert property (@(posedge clock_in) disable iff (!rst_n)
    !stat_in.gen_to_gen_mode && !ctrl_in.gen_b_start_delay |=> !gen_b_led_out)
    else $error("gen b lamp lit outside mode");
  retx_blink_a: assert property (@(posedge clock_in) disable iff (!rst_n)
    ctrl_in.retransfer_delay && !ctrl_in.retransfer_relay |=> retransfer_led_out == blink_q)
    else $error("retransfer lamp not blinking");
  neutral_dark_a: assert property (@(posedge clock_in) disable iff (!rst_n)
    !ctrl_in.neutral_position_delay |=> !neutral_pos_led_out)
    else $error("neutral lamp lit without delay");
  exer_off_a: assert property (@(posedge clock_in) disable iff (!rst_n)
    !exercise_enabled |=> !exerciser_led_out)
    else $error("exerciser lamp lit while disabled");
  nwarn_fit_a: assert property (@(posedge clock_in) disable iff (!rst_n)
    !stat_in.load_monitor_fitted |=> !neutral_warn_out)
    else $error("neutral warning without monitoring");
  pref_clear_a: assert property (@(posedge clock_in) disable iff (!rst_n)
    !stat_in.preferred_is_src2 |=> !preferred_event)
    else $error("preferred event stuck at source one");
  power_seq_a: assert property (@(posedge clock_in) disable iff (!rst_n)
    pstate == SLA_PWR_RUN && power_lost_in |=> ##1 net_shutdown_out && shutdown_start_out)
    else $error("power loss not signalled");

  flash_seen_c: cover property (@(posedge clock_in) disable iff (!rst_n) event_active && status_led_out);
  ack_seen_c: cover property (@(posedge clock_in) disable iff (!rst_n) event_active ##1 !event_active);
  exer_blink_c: cover property (@(posedge clock_in) disable iff (!rst_n) exercise_enabled && ctrl_in.exercise_active);
  power_off_c: cover property (@(posedge clock_in) disable iff (!rst_n) power_off_out);
endmodule
`default_nettype wire

// ===== rtl/sla_flash.sv
// fault code flash-out sequencer for the status lamp
`timescale 1ns/10ps
`default_nettype none
module sla_flash
  import sla_pkg::*;
#(
  parameter int unsigned FLASH_ON = SLA_FLASH_ON_CYC,
  parameter int unsigned DIGIT_GAP = SLA_DIGIT_GAP_CYC,
  parameter int unsigned REPEAT_GAP = SLA_REPEAT_GAP_CYC
) (
  input wire logic clock_in,
  input wire logic rst_n,
  input wire logic run_in,
  input wire logic [4*SLA_DIGITS-1:0] code_in,
  output logic lamp_out
);
  typedef enum logic [1:0] {SLA_IDLE, SLA_ON, SLA_OFF, SLA_GAP} sla_fstate_t;
  localparam int unsigned TW = $clog2(REPEAT_GAP + 1);
  sla_fstate_t state;
  logic [TW-1:0] timer;
  logic [1:0] digit;
  logic [3:0] pulses;
  wire logic [3:0] cur_digit = code_in[4*digit +: 4];
  wire logic timer_done = (timer == '0);
  // index counts down, so the digit shown last of a round is index zero
  wire logic last_digit = (digit == 2'h0);
  // pulse count of this digit; a zero digit shows ten flashes
  wire logic [3:0] digit_len = (cur_digit == SLA_DIGIT_ZERO) ? 4'hA : cur_digit;
  // digits most significant first: index counts down
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= SLA_IDLE;
      timer <= '0;
      digit <= '0;
      pulses <= '0;
      lamp_out <= 1'b0;
    end else if (!run_in) begin
      state <= SLA_IDLE;
      lamp_out <= 1'b0;
    end else begin
      timer <= timer_done ? timer : timer - TW'(1);
      unique case (state)
        SLA_IDLE: begin
          state <= SLA_GAP;
          digit <= 2'(SLA_DIGITS - 1);
          timer <= TW'(DIGIT_GAP - 1);
          pulses <= '0;
        end
        SLA_GAP: if (timer_done) begin
          // load next digit's pulse count, lamp on
          state <= SLA_ON;
          pulses <= digit_len - 4'h1;
          lamp_out <= 1'b1;
          timer <= TW'(FLASH_ON - 1);
        end
        SLA_ON: if (timer_done) begin
          state <= SLA_OFF;
          lamp_out <= 1'b0;
          if (pulses != 4'h0) begin
            timer <= TW'(FLASH_ON - 1);
          end else if (last_digit) begin
            timer <= TW'(REPEAT_GAP - 1); // long pause before repeat
          end else begin
            timer <= TW'(DIGIT_GAP - 1); // short pause between digits
          end
        end
        SLA_OFF: if (timer_done) begin
          if (pulses != 4'h0) begin
            state <= SLA_ON;
            pulses <= pulses - 4'h1;
            lamp_out <= 1'b1;
            timer <= TW'(FLASH_ON - 1);
          end else begin
            digit <= (digit == 2'h0) ? 2'(SLA_DIGITS - 1) : digit - 2'h1;
            state <= SLA_GAP;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== rtl/sla_pkg.sv
// constants and types shared by the status lamp annunciator
// What this block does
// - No active event: status lamp toggles as heartbeat at half a hertz.
// - Active event: status lamp flashes its code until front reset acknowledges it.
// - Code shown digit by digit, short gap between digits, long gap before repeat.
// - Source one available lamp follows source one within limits.
// - Source two available lamp follows source two within limits.
// - Generator A start lamp steady while source two start is commanded.
// - Generator A start lamp blinks while its start delay counts.
// - Generator B start lamp steady only in generator-to-generator mode when commanded.
// - Generator B start lamp blinks while its start delay counts.
// - Retransfer lamp steady while retransfer relay is energized.
// - Retransfer lamp blinks while retransfer delay counts.
// - Transfer lamp steady while transfer relay is energized.
// - Transfer lamp blinks while transfer delay counts.
// - Neutral position lamp blinks while its delay runs, dark otherwise.
// - Exerciser lamp steady while schedule enabled, blinks during exercise period.
// - Push-button press or display command toggles exercise enable; disabled means dark.
// - With load monitoring, neutral warning asserts while neutral current exceeds threshold.
// - Utility-to-utility only: preferred event set on change, cleared when source one.
// - Power loss: signal network card, trigger shutdown, power off when sequences finish.
package sla_pkg;
  // ==========================================================
  // timing
  localparam int unsigned SLA_CLK_HZ = 100000000;
  localparam int unsigned SLA_BLINK_HALF_MS = 1000;
  localparam int unsigned SLA_BLINK_HALF_CYC = SLA_CLK_HZ / 1000 * SLA_BLINK_HALF_MS;
  localparam int unsigned SLA_FLASH_ON_MS = 250;
  localparam int unsigned SLA_FLASH_ON_CYC = SLA_CLK_HZ / 1000 * SLA_FLASH_ON_MS;
  localparam int unsigned SLA_DIGIT_GAP_MS = 1000;
  localparam int unsigned SLA_DIGIT_GAP_CYC = SLA_CLK_HZ / 1000 * SLA_DIGIT_GAP_MS;
  localparam int unsigned SLA_REPEAT_GAP_MS = 3000;
  localparam int unsigned SLA_REPEAT_GAP_CYC = SLA_CLK_HZ / 1000 * SLA_REPEAT_GAP_MS;
  // ==========================================================
  // fault code layout: three decimal digits
  localparam int unsigned SLA_DIGITS = 3;
  localparam logic [3:0] SLA_DIGIT_ZERO = 4'h0;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic gen_a_start_cmd;
    logic gen_a_start_delay;
    logic gen_b_start_cmd;
    logic gen_b_start_delay;
    logic retransfer_relay;
    logic retransfer_delay;
    logic transfer_relay;
    logic transfer_delay;
    logic neutral_position_delay;
    logic exercise_active;
  } sla_ctrl_t;
  typedef struct packed {
    logic src1_ok;
    logic src2_ok;
    logic gen_to_gen_mode;
    logic util_to_util_mode;
    logic load_monitor_fitted;
    logic neutral_over;
    logic preferred_is_src2;
  } sla_stat_t;
endpackage

// ===== rtl/sla_tick.sv
// enable pulse divider
`timescale 1ns/10ps
`default_nettype none
module sla_tick #(
  parameter int unsigned PERIOD = 100
) (
  input wire logic clock_in,
  input wire logic rst_n,
  input wire logic clear_in,
  output logic tick_out
);
  localparam int unsigned CW = $clog2(PERIOD + 1);
  logic [CW-1:0] count;
  wire logic at_end = (count == CW'(PERIOD - 1));
  // free counter, one-cycle pulse at wrap; clear restarts the interval
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      tick_out <= 1'b0;
    end else begin
      count <= (at_end || clear_in) ? '0 : count + CW'(1);
      tick_out <= at_end && !clear_in;
    end
  end
endmodule
`default_nettype wire

// ===== sim/sla_annunciator_test.sv
// self-checking bench for the status lamp annunciator
`timescale 1ns/10ps
`default_nettype none
module sla_annunciator_test
  import sla_pkg::*;
;
  // ==========================================================
  // stimulus and observation
  localparam int unsigned BH = 10;
  logic clock_in = 1'b0;
  logic rst_n = 1'b0;
  sla_ctrl_t ctrl = '0;
  sla_stat_t stat = '0;
  logic event_raise = 1'b0;
  logic [11:0] event_code = 12'h000;
  logic display_toggle = 1'b0;
  logic power_lost = 1'b0;
  logic shutdown_done = 1'b0;
  logic press_exer = 1'b0;
  logic press_reset = 1'b0;
  logic flash_clear = 1'b0;
  wire logic exer_button;
  wire logic panel_reset;
  wire logic [7:0] flash_count;
  wire logic [15:0] outs;
  int fail_count = 0;
  int n_compared = 0;
  int lamp_of[10] = '{8, 7, 6, 6, 5, 5, 4, 4, 3, 3};
  int mode_of[10] = '{2, 2, 2, 1, 2, 1, 2, 1, 2, 1};
  always #5 clock_in = ~clock_in;
  // ==========================================================
  // design and operator
  sla_annunciator #(.BLINK_HALF(BH), .FLASH_ON(4), .DIGIT_GAP(12), .REPEAT_GAP(30)) i_dut (
    .clock_in(clock_in), .rst_n_in(rst_n), .ctrl_in(ctrl), .stat_in(stat),
    .event_raise_in(event_raise), .event_code_in(event_code), .panel_reset_in(panel_reset),
    .exer_button_in(exer_button), .exer_display_toggle_in(display_toggle),
    .power_lost_in(power_lost), .shutdown_done_in(shutdown_done),
    .status_led_out(outs[0]), .src1_led_out(outs[1]), .src2_led_out(outs[2]),
    .gen_a_led_out(outs[3]), .gen_b_led_out(outs[4]), .retransfer_led_out(outs[5]),
    .transfer_led_out(outs[6]), .neutral_pos_led_out(outs[7]), .exerciser_led_out(outs[8]),
    .exercise_enabled_out(outs[9]), .event_active_out(outs[10]), .neutral_warn_out(outs[11]),
    .preferred_event_out(outs[12]), .net_shutdown_out(outs[13]), .shutdown_start_out(outs[14]),
    .power_off_out(outs[15])
  );
  sla_operator i_op (
    .clock_in(clock_in), .status_led_in(outs[0]), .clear_in(flash_clear),
    .press_exer_in(press_exer), .press_reset_in(press_reset),
    .exer_button_out(exer_button), .panel_reset_out(panel_reset), .flash_count_out(flash_count)
  );
  // ==========================================================
  // checking helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if ((fail_count == 0) && (n_compared > 0)) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // lets registered outputs follow, then samples off the edge
  task automatic settle();
    repeat (3) @(posedge clock_in);
    #1;
  endtask
  // bounded wait; a wait that runs out ends the run
  task automatic wait_lvl(input int idx, input logic lvl, input string what);
    for (int k = 0; (k < 20) && (outs[idx] !== lvl); k++) begin
      @(posedge clock_in);
      #1;
    end
    check(what, 16'(outs[idx]), 16'(lvl));
    if (outs[idx] !== lvl) close_out();
  endtask
  // mode 0 dark, 1 steady, 2 blinking with half period BH over 6*BH cycles
  task automatic lamp(input int idx, input int mode, input string what);
    int ones;
    int flips;
    logic prev;
    settle();
    prev = outs[idx];
    ones = 0;
    flips = 0;
    repeat (6 * BH) begin
      @(posedge clock_in);
      #1;
      if (outs[idx] === 1'b1) ones++;
      if (outs[idx] !== prev) flips++;
      prev = outs[idx];
    end
    if (mode == 2) check(what, 16'((flips >= 5) && (flips <= 7)), 16'h0001);
    else check(what, 16'(ones), (mode == 1) ? 16'(6 * BH) : 16'h0000);
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (4) @(posedge clock_in);
    #1;
    check("outputs in reset", outs, 16'h0000);
    repeat (4) @(posedge clock_in);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock_in);
    #1;
  endtask
  // ==========================================================
  // scenarios
  initial begin
    repeat (20000) @(posedge clock_in);
    fail_count++;
    close_out();
  end
  initial begin
    do_reset();
    lamp(0, 2, "heartbeat");
    // source lamps follow availability in both directions
    @(posedge clock_in);
    stat.src1_ok <= 1'b1;
    lamp(1, 1, "src1 lamp on");
    lamp(2, 0, "src2 lamp dark");
    @(posedge clock_in);
    stat.src1_ok <= 1'b0;
    stat.src2_ok <= 1'b1;
    lamp(1, 0, "src1 lamp off");
    lamp(2, 1, "src2 lamp on");
    // one timer or relay at a time; each lamp steady or blinking
    @(posedge clock_in);
    stat.gen_to_gen_mode <= 1'b1;
    for (int i = 1; i < 10; i++) begin
      @(posedge clock_in);
      ctrl <= sla_ctrl_t'(10'h001 << i);
      lamp(lamp_of[i], mode_of[i], "timer lamp");
    end
    @(posedge clock_in);
    ctrl <= '0;
    settle();
    check("timer lamps idle", 16'(outs[8:3]), 16'h0000);
    // start B command ignored outside generator-to-generator mode
    @(posedge clock_in);
    stat.gen_to_gen_mode <= 1'b0;
    ctrl.gen_b_start_cmd <= 1'b1;
    lamp(4, 0, "gen b outside mode");
    // exerciser: button on, steady, blink in period, display off
    @(posedge clock_in);
    ctrl <= '0;
    press_exer <= 1'b1;
    @(posedge clock_in);
    press_exer <= 1'b0;
    wait_lvl(9, 1'b1, "exercise enabled");
    lamp(8, 1, "exerciser steady");
    @(posedge clock_in);
    ctrl.exercise_active <= 1'b1;
    lamp(8, 2, "exerciser period");
    @(posedge clock_in);
    ctrl <= '0;
    display_toggle <= 1'b1;
    @(posedge clock_in);
    display_toggle <= 1'b0;
    wait_lvl(9, 1'b0, "exercise disabled");
    lamp(8, 0, "exerciser dark");
    // neutral warning gated by load monitoring
    @(posedge clock_in);
    stat.load_monitor_fitted <= 1'b1;
    stat.neutral_over <= 1'b1;
    settle();
    check("neutral warn", 16'(outs[11]), 16'h0001);
    @(posedge clock_in);
    stat.load_monitor_fitted <= 1'b0;
    settle();
    check("neutral warn unfitted", 16'(outs[11]), 16'h0000);
    // preferred source event only in utility-to-utility mode
    @(posedge clock_in);
    stat.preferred_is_src2 <= 1'b1;
    settle();
    check("preferred outside mode", 16'(outs[12]), 16'h0000);
    @(posedge clock_in);
    stat.preferred_is_src2 <= 1'b0;
    stat.util_to_util_mode <= 1'b1;
    repeat (2) @(posedge clock_in);
    stat.preferred_is_src2 <= 1'b1;
    settle();
    check("preferred to src2", 16'(outs[12]), 16'h0001);
    @(posedge clock_in);
    stat.preferred_is_src2 <= 1'b0;
    settle();
    check("preferred back src1", 16'(outs[12]), 16'h0000);
    // code 1-2-1: four flashes per round, long dark gap before the repeat
    @(posedge clock_in);
    event_code <= 12'h121;
    event_raise <= 1'b1;
    @(posedge clock_in);
    event_raise <= 1'b0;
    wait_lvl(10, 1'b1, "event active");
    @(posedge clock_in);
    flash_clear <= 1'b1;
    @(posedge clock_in);
    flash_clear <= 1'b0;
    repeat (76) @(posedge clock_in);
    #1;
    check("flashes first round", 16'(flash_count), 16'h0004);
    repeat (8) @(posedge clock_in);
    #1;
    check("repeat gap dark", 16'(flash_count), 16'h0004);
    check("repeat gap lamp", 16'(outs[0]), 16'h0000);
    repeat (72) @(posedge clock_in);
    #1;
    check("flashes second round", 16'(flash_count), 16'h0008);
    @(posedge clock_in);
    press_reset <= 1'b1;
    @(posedge clock_in);
    press_reset <= 1'b0;
    wait_lvl(10, 1'b0, "event acknowledged");
    lamp(0, 2, "heartbeat resumes");
    // power loss: notify, run shutdown, then off until reset
    @(posedge clock_in);
    power_lost <= 1'b1;
    wait_lvl(14, 1'b1, "shutdown started");
    check("net notified", 16'(outs[15:13]), 16'h0003);
    @(posedge clock_in);
    shutdown_done <= 1'b1;
    wait_lvl(15, 1'b1, "powered off");
    @(posedge clock_in);
    power_lost <= 1'b0;
    shutdown_done <= 1'b0;
    settle();
    check("stays off", 16'(outs[15]), 16'h0001);
    do_reset();
    check("off cleared", 16'(outs[15]), 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire

// ===== sim/sla_operator.sv
// operator at the panel: presses switches on request and counts status lamp flashes
`timescale 1ns/10ps
`default_nettype none
module sla_operator (
  input wire logic clock_in,
  input wire logic status_led_in,
  input wire logic clear_in,
  input wire logic press_exer_in,
  input wire logic press_reset_in,
  output logic exer_button_out,
  output logic panel_reset_out,
  output logic [7:0] flash_count_out
);
  // ==========================================================
  // switches
  logic [1:0] exer_hold = 2'h0;
  logic reset_press = 1'b0;
  logic last_led = 1'b0;
  logic [7:0] flashes = 8'h00;
  // a finger stays on the push-button for three cycles, then lets go
  always @(posedge clock_in) begin
    if (press_exer_in) begin
      exer_hold <= 2'h3;
    end else if (exer_hold != 2'h0) begin
      exer_hold <= exer_hold - 2'h1;
    end
    reset_press <= press_reset_in;
  end
  assign exer_button_out = (exer_hold != 2'h0);
  assign panel_reset_out = reset_press;
  // ==========================================================
  // watching the status lamp
  // counts rising edges only, so a lamp stuck on counts once
  always @(posedge clock_in) begin
    last_led <= status_led_in;
    if (clear_in) begin
      flashes <= 8'h00;
    end else if ((status_led_in === 1'b1) && (last_led !== 1'b1)) begin
      flashes <= flashes + 8'h01;
    end
  end
  assign flash_count_out = flashes;
endmodule
`default_nettype wire
